// file: include/hdp_map.svh
// address map, field positions, reset values and timing counts of the host packing block
`ifndef HDP_MAP_SVH
`define HDP_MAP_SVH

`define HDP_ADDR_W 20
`define HDP_DATA_W 48
`define HDP_CFG_W 32
`define HDP_NUM_FIFO 4
`define HDP_FIFO_IDX_W 2

`define HDP_CFG_RESET 32'h0000_0010
`define HDP_CFG_IWT 3
`define HDP_CFG_HPM_LO 4
`define HDP_CFG_HPM_HI 5
`define HDP_CFG_HIGH_HALF_FIRST 6
`define HDP_CFG_FLUSH 7
`define HDP_CFG_BLOCK0_WIDE_DATA 8
`define HDP_CFG_BLOCK1_WIDE_DATA 9

`define HDP_IOP_LSB 8
`define HDP_CFG_ADDR 20'h0_0000
`define HDP_FIFO_LSB 2
`define HDP_FIFO_PAGE 18'h0_0010
`define HDP_LINK_LSB 3
`define HDP_LINK_PAGE 17'h0_0009
`define HDP_BLK_BIT 17

`define HDP_FLUSH_LAT 2
`define HDP_PARTS_32 2'h2
`define HDP_PARTS_48 2'h3
`define HDP_PHASE_0 2'h0
`define HDP_PHASE_1 2'h1
`define HDP_PHASE_2 2'h2

`endif

// file: include/hdp_pkg.sv
// types shared by the host packing block
`include "hdp_map.svh"

package hdp_pkg;

    typedef enum logic [1:0] {
        HDP_PACK_NONE  = 2'h0,
        HDP_PACK_16_32 = 2'h1,
        HDP_PACK_16_48 = 2'h2,
        HDP_PACK_32_48 = 2'h3
    } hdp_pack_e;

    typedef enum logic [4:0] {
        HDP_IDLE   = 5'h01,
        HDP_DECIDE = 5'h02,
        HDP_FETCH  = 5'h04,
        HDP_DRIVE  = 5'h08,
        HDP_DONE   = 5'h10
    } hdp_state_e;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [`HDP_ADDR_W-1:0] addr;
        logic [`HDP_DATA_W-1:0] data;
    } hdp_host_s;

    typedef struct packed {
        logic req;
        logic we;
        logic [`HDP_ADDR_W-1:0] addr;
        logic [`HDP_DATA_W-1:0] wdata;
        logic wide48;
        logic upper32;
    } hdp_int_s;

    typedef struct packed {
        hdp_pack_e pack_sel;
        logic dir;
    } hdp_chan_s;

    typedef hdp_chan_s [`HDP_NUM_FIFO-1:0] hdp_chan_arr_t;

endpackage

// file: hw/hdp_sync2.sv
// two-stage synchroniser for host pins
module hdp_sync2 #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // first stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (reset) begin
            meta_r <= '0;
            q_r <= '0;
        end else if (clk_en) begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;

endmodule

// file: hw/hdp_host_data_packing.sv
// host interface data packing and unpacking between host bus and internal words
`include "hdp_map.svh"

module hdp_host_data_packing (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input hdp_pkg::hdp_host_s host_in,
    output logic [`HDP_DATA_W-1:0] host_data_out,
    output logic host_data_oe_n,
    output logic host_ready,
    output hdp_pkg::hdp_int_s int_out,
    input wire logic int_ack,
    input wire logic [`HDP_DATA_W-1:0] int_rdata,
    input hdp_pkg::hdp_chan_arr_t channel_control,
    input wire logic core_cfg_we,
    input wire logic [`HDP_CFG_W-1:0] core_cfg_wdata,
    output logic [`HDP_CFG_W-1:0] core_cfg_rdata,
    output logic [1:0] pack_progress
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation and access detection

    hdp_pkg::hdp_host_s hs;

    hdp_sync2 #(
        .W($bits(hdp_pkg::hdp_host_s))
    ) u_sync (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en),
        .d(host_in),
        .q(hs)
    );

    logic acc_prev_r;
    wire acc_now = !hs.cs_n && (!hs.rd_n || !hs.wr_n);
    wire acc_start = acc_now && !acc_prev_r;

    // synchroniser clears to zero, which reads as a held strobe; no false start after reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            acc_prev_r <= 1'b1;
        end else if (clk_en) begin
            acc_prev_r <= acc_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state

    hdp_pkg::hdp_state_e state_r;
    hdp_pkg::hdp_state_e state_nxt;
    logic [`HDP_ADDR_W-1:0] addr_r;
    logic [`HDP_DATA_W-1:0] din_r;
    logic is_rd_r;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic [`HDP_DATA_W-1:0] buf_r;
    logic [`HDP_DATA_W-1:0] buf_nxt;
    logic [`HDP_DATA_W-1:0] dout_r;
    logic [`HDP_DATA_W-1:0] dout_nxt;
    logic [`HDP_CFG_W-1:0] cfg_r;
    logic [`HDP_FLUSH_LAT-1:0] flush_pipe_r;
    logic int_req_r;
    logic int_we_r;
    logic [`HDP_ADDR_W-1:0] int_addr_r;
    logic [`HDP_DATA_W-1:0] int_wdata_r;
    logic int_wide_r;
    logic int_upper_r;

    ////////////////////////////////////////////////////////////////////////////
    // target decode and word width selection

    wire in_iop = addr_r[`HDP_ADDR_W-1:`HDP_IOP_LSB] == '0;
    wire tgt_mem = !in_iop;
    wire tgt_fifo = addr_r[`HDP_ADDR_W-1:`HDP_FIFO_LSB] == `HDP_FIFO_PAGE;
    wire tgt_link = addr_r[`HDP_ADDR_W-1:`HDP_LINK_LSB] == `HDP_LINK_PAGE;
    wire tgt_cfg = addr_r == `HDP_CFG_ADDR;
    wire [`HDP_FIFO_IDX_W-1:0] fifo_idx = addr_r[`HDP_FIFO_IDX_W-1:0];

    wire [1:0] hpm_bits = cfg_r[`HDP_CFG_HPM_HI:`HDP_CFG_HPM_LO];
    wire high_half_first = cfg_r[`HDP_CFG_HIGH_HALF_FIRST];
    wire instr_width_override = cfg_r[`HDP_CFG_IWT];
    wire blk_wide = addr_r[`HDP_BLK_BIT] ? cfg_r[`HDP_CFG_BLOCK1_WIDE_DATA] : cfg_r[`HDP_CFG_BLOCK0_WIDE_DATA];

    // fifo accesses follow the channel's own selection; host must keep widths matched
    wire hdp_pkg::hdp_pack_e host_sel = hdp_pkg::hdp_pack_e'(hpm_bits);
    wire hdp_pkg::hdp_pack_e fifo_sel = channel_control[fifo_idx].pack_sel;
    wire hdp_pkg::hdp_pack_e sel = tgt_fifo ? fifo_sel : host_sel;

    wire sel_none = sel == hdp_pkg::HDP_PACK_NONE;
    wire sel_48 = (sel == hdp_pkg::HDP_PACK_16_48) || (sel == hdp_pkg::HDP_PACK_32_48);
    wire ext16 = (sel == hdp_pkg::HDP_PACK_16_32) || (sel == hdp_pkg::HDP_PACK_16_48);

    // instructions may sit in any block, so the override ignores block width
    wire mem_wide = sel_none ? (instr_width_override || blk_wide) : sel_48;
    wire wide48 = tgt_mem ? mem_wide : ((tgt_fifo || tgt_link) ? sel_48 : 1'b0);
    wire upper32 = tgt_mem && (sel == hdp_pkg::HDP_PACK_16_32) && blk_wide;
    wire m3248 = (sel == hdp_pkg::HDP_PACK_32_48) && wide48;

    wire [1:0] parts = wide48 ? `HDP_PARTS_48 : `HDP_PARTS_32;
    wire last_half = cnt_r == (parts - 2'h1);
    wire [1:0] pos = high_half_first ? (parts - 2'h1 - cnt_r) : cnt_r;
    wire [5:0] half_lsb = {pos, 4'h0};
    wire [15:0] half_in = din_r[31:16];

    ////////////////////////////////////////////////////////////////////////////
    // write assembly and read fetch decisions

    logic [`HDP_DATA_W-1:0] wr_word;
    logic wr_issue;
    logic rd_fetch;
    logic [`HDP_DATA_W-1:0] wr_buf;

    always_comb begin
        wr_word = buf_r;
        wr_buf = buf_r;
        wr_issue = 1'b0;
        rd_fetch = 1'b0;
        if (ext16) begin
            // one half-word per bus cycle on the middle lines
            wr_word[half_lsb +: 16] = half_in;
            wr_buf = wr_word;
            wr_issue = last_half;
            rd_fetch = cnt_r == `HDP_PHASE_0;
        end else if (m3248) begin
            case (cnt_r)
                `HDP_PHASE_0: begin
                    wr_buf = {din_r[47:16], 16'h0000};
                    rd_fetch = 1'b1;
                end
                `HDP_PHASE_1: begin
                    wr_word = {buf_r[47:16], din_r[31:16]};
                    wr_buf = {32'h0000_0000, din_r[47:32]};
                    wr_issue = 1'b1;
                    rd_fetch = 1'b1;
                end
                default: begin
                    wr_word = {din_r[47:16], buf_r[15:0]};
                    wr_issue = 1'b1;
                end
            endcase
        end else begin
            // lowest lines carry no data without packing
            wr_word = wide48 ? {din_r[47:16], 16'h0000} : {16'h0000, din_r[47:16]};
            wr_issue = 1'b1;
            rd_fetch = 1'b1;
        end
    end

    always_comb begin
        cnt_nxt = `HDP_PHASE_0;
        if (ext16) begin
            cnt_nxt = last_half ? `HDP_PHASE_0 : cnt_r + 2'h1;
        end else if (m3248) begin
            cnt_nxt = (cnt_r == `HDP_PHASE_2) ? `HDP_PHASE_0 : cnt_r + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read formatting

    wire [`HDP_DATA_W-1:0] fetch_data = tgt_cfg ? {16'h0000, cfg_r} : int_rdata;
    wire fetch_done = tgt_cfg || (int_req_r && int_ack);
    wire [`HDP_DATA_W-1:0] rd_src = (state_r == hdp_pkg::HDP_FETCH) ? fetch_data : buf_r;
    logic [`HDP_DATA_W-1:0] rd_fmt;

    always_comb begin
        rd_fmt = '0;
        if (ext16) begin
            rd_fmt[31:16] = rd_src[half_lsb +: 16];
        end else if (m3248) begin
            case (cnt_r)
                `HDP_PHASE_0: rd_fmt = {rd_src[47:16], 16'h0000};
                `HDP_PHASE_1: rd_fmt = {rd_src[15:0], buf_r[15:0], 16'h0000};
                default: rd_fmt = {buf_r[47:16], 16'h0000};
            endcase
        end else begin
            rd_fmt = wide48 ? {rd_src[47:16], 16'h0000} : {rd_src[31:0], 16'h0000};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // access sequencer

    wire in_decide = state_r == hdp_pkg::HDP_DECIDE;
    wire in_fetch = state_r == hdp_pkg::HDP_FETCH;
    // a new part waits until the previous internal access finishes
    wire can_go = in_decide && !int_req_r;
    wire do_write = can_go && !is_rd_r;
    wire do_rd_buf = can_go && is_rd_r && !rd_fetch;
    wire do_rd_req = can_go && is_rd_r && rd_fetch;
    wire rd_got = in_fetch && fetch_done;
    wire host_cfg_we = do_write && wr_issue && tgt_cfg;
    wire int_issue_wr = do_write && wr_issue && !tgt_cfg;
    wire int_issue_rd = do_rd_req && !tgt_cfg;
    wire part_done = do_write || do_rd_buf || rd_got;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            hdp_pkg::HDP_IDLE: begin
                if (acc_start) begin
                    state_nxt = hdp_pkg::HDP_DECIDE;
                end
            end
            hdp_pkg::HDP_DECIDE: begin
                if (do_write) begin
                    state_nxt = hdp_pkg::HDP_DONE;
                end else if (do_rd_buf) begin
                    state_nxt = hdp_pkg::HDP_DRIVE;
                end else if (do_rd_req) begin
                    state_nxt = hdp_pkg::HDP_FETCH;
                end
            end
            hdp_pkg::HDP_FETCH: begin
                if (fetch_done) begin
                    state_nxt = hdp_pkg::HDP_DRIVE;
                end
            end
            hdp_pkg::HDP_DRIVE, hdp_pkg::HDP_DONE: begin
                if (!acc_now) begin
                    state_nxt = hdp_pkg::HDP_IDLE;
                end
            end
            default: state_nxt = hdp_pkg::HDP_IDLE;
        endcase
    end

    always_comb begin
        buf_nxt = buf_r;
        if (do_write) begin
            buf_nxt = wr_buf;
        end else if (rd_got) begin
            buf_nxt = fetch_data;
        end
    end

    assign dout_nxt = (do_rd_buf || rd_got) ? rd_fmt : dout_r;

    // flush wins over a part finishing in the same cycle
    wire flush_now = flush_pipe_r[`HDP_FLUSH_LAT-1];

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r <= hdp_pkg::HDP_IDLE;
            addr_r <= '0;
            din_r <= '0;
            is_rd_r <= 1'b0;
            buf_r <= '0;
            dout_r <= '0;
            cnt_r <= `HDP_PHASE_0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            buf_r <= buf_nxt;
            dout_r <= dout_nxt;
            if (state_r == hdp_pkg::HDP_IDLE && acc_start) begin
                addr_r <= hs.addr;
                din_r <= hs.data;
                is_rd_r <= !hs.rd_n;
            end
            // only host parts and a flush move the counter; release or other masters leave it
            if (flush_now) begin
                cnt_r <= `HDP_PHASE_0;
            end else if (part_done) begin
                cnt_r <= cnt_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // internal access request

    always_ff @(posedge mclk) begin
        if (reset) begin
            int_req_r <= 1'b0;
            int_we_r <= 1'b0;
            int_addr_r <= '0;
            int_wdata_r <= '0;
            int_wide_r <= 1'b0;
            int_upper_r <= 1'b0;
        end else if (clk_en) begin
            if (int_issue_wr || int_issue_rd) begin
                int_req_r <= 1'b1;
                int_we_r <= int_issue_wr;
                int_addr_r <= addr_r;
                int_wdata_r <= wr_word;
                int_wide_r <= wide48;
                int_upper_r <= upper32;
            end else if (int_ack) begin
                int_req_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration register

    wire core_flush = core_cfg_we && core_cfg_wdata[`HDP_CFG_FLUSH];
    wire host_flush = host_cfg_we && wr_word[`HDP_CFG_FLUSH];
    logic [`HDP_CFG_W-1:0] cfg_src;
    logic [`HDP_CFG_W-1:0] cfg_nxt;

    always_comb begin
        cfg_src = core_cfg_we ? core_cfg_wdata : wr_word[`HDP_CFG_W-1:0];
        cfg_nxt = cfg_r;
        if (core_cfg_we || host_cfg_we) begin
            cfg_nxt = cfg_src;
            cfg_nxt[`HDP_CFG_FLUSH] = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_r <= `HDP_CFG_RESET;
            flush_pipe_r <= '0;
        end else if (clk_en) begin
            cfg_r <= cfg_nxt;
            flush_pipe_r <= {flush_pipe_r[`HDP_FLUSH_LAT-2:0], core_flush || host_flush};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign host_data_out = dout_r;
    assign host_data_oe_n = state_r != hdp_pkg::HDP_DRIVE;
    assign host_ready = (state_r == hdp_pkg::HDP_DRIVE) || (state_r == hdp_pkg::HDP_DONE);
    assign int_out = '{req: int_req_r, we: int_we_r, addr: int_addr_r, wdata: int_wdata_r,
                       wide48: int_wide_r, upper32: int_upper_r};
    assign core_cfg_rdata = cfg_r;
    assign pack_progress = cnt_r;

endmodule

// file: tb/hdp_host_data_packing_asserts.sv
// port checker for the host packing block
`include "hdp_map.svh"
////////////////////////////////////////////////////////////////////////////////
module hdp_host_data_packing_asserts (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input hdp_pkg::hdp_host_s host_in,
    input wire logic [`HDP_DATA_W-1:0] host_data_out,
    input wire logic host_data_oe_n,
    input wire logic host_ready,
    input hdp_pkg::hdp_int_s int_out,
    input wire logic int_ack,
    input wire logic [`HDP_DATA_W-1:0] int_rdata,
    input hdp_pkg::hdp_chan_arr_t channel_control,
    input wire logic core_cfg_we,
    input wire logic [`HDP_CFG_W-1:0] core_cfg_wdata,
    input wire logic [`HDP_CFG_W-1:0] core_cfg_rdata,
    input wire logic [1:0] pack_progress
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire [1:0] mode = core_cfg_rdata[`HDP_CFG_HPM_HI:`HDP_CFG_HPM_LO];
    wire mem_acc = int_out.req && (int_out.addr[19:8] != 12'h0);
    wire blk_wide = int_out.addr[`HDP_BLK_BIT] ? core_cfg_rdata[9] : core_cfg_rdata[8];
    wire want48 = (mode != 2'h0) ? mode[1] : (core_cfg_rdata[`HDP_CFG_IWT] | blk_wide);
    sequence s_taken; int_out.req && int_ack; endsequence
    sequence s_waiting; int_out.req && !int_ack; endsequence
    sequence s_release; $rose(host_in.cs_n); endsequence
    property p_rst_val; $fell(reset) |-> core_cfg_rdata == `HDP_CFG_RESET && pack_progress == 2'h0; endproperty
    a_rst_val: assert property (p_rst_val) else $error("config reset value wrong");
    property p_flush_rd; core_cfg_rdata[`HDP_CFG_FLUSH] == 1'b0; endproperty
    a_flush_rd: assert property (p_flush_rd) else $error("flush bit read as one");
    property p_flush; core_cfg_we && core_cfg_wdata[`HDP_CFG_FLUSH] |-> ##[3:4] pack_progress == 2'h0; endproperty
    a_flush: assert property (p_flush) else $error("flush did not clear progress");
    property p_low_lanes; !host_data_oe_n |-> host_ready && host_data_out[15:0] == 16'h0; endproperty
    a_low_lanes: assert property (p_low_lanes) else $error("low data lines not zero");
    property p_half_lanes; !host_data_oe_n && (mode[1] ^ mode[0]) |-> host_data_out[47:32] == 16'h0; endproperty
    a_half_lanes: assert property (p_half_lanes) else $error("upper lines not zero");
    property p_hold; s_waiting |=> int_out.req && $stable(int_out.wdata) && $stable(int_out.addr); endproperty
    a_hold: assert property (p_hold) else $error("internal request dropped early");
    property p_ack_clr; s_taken |=> !int_out.req; endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("request stayed after ack");
    property p_rel; s_release |-> ##[2:5] !host_ready; endproperty
    a_rel: assert property (p_rel) else $error("ready not dropped after release");
    property p_width; mem_acc |-> int_out.wide48 == want48; endproperty
    a_width: assert property (p_width) else $error("internal word width wrong");
    property p_upper; mem_acc && mode == 2'h1 |-> int_out.upper32 == blk_wide; endproperty
    a_upper: assert property (p_upper) else $error("upper placement wrong");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind hdp_host_data_packing hdp_host_data_packing_asserts chk_u (.mclk(mclk), .reset(reset),
    .clk_en(clk_en), .host_in(host_in), .host_data_out(host_data_out),
    .host_data_oe_n(host_data_oe_n), .host_ready(host_ready), .int_out(int_out),
    .int_ack(int_ack), .int_rdata(int_rdata), .channel_control(channel_control),
    .core_cfg_we(core_cfg_we), .core_cfg_wdata(core_cfg_wdata),
    .core_cfg_rdata(core_cfg_rdata), .pack_progress(pack_progress));

// file: tb/hdp_host_model.sv
// host processor model driving the packing block's host pins
module hdp_host_model (
    input wire logic mclk,
    input wire logic host_ready,
    input wire logic [47:0] host_data_out,
    output hdp_pkg::hdp_host_s host_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial host_in = '1;
    // one access at a time, held whole until ready is seen
    task automatic acc(input logic we, input logic [19:0] a, input logic [47:0] d,
                       input int gap, output logic [47:0] q);
        @(posedge mclk);
        host_in.addr <= a;
        host_in.data <= d;
        host_in.cs_n <= 1'b0;
        host_in.rd_n <= we;
        host_in.wr_n <= !we;
        // a stuck ready is left to the bench watchdog
        do begin
            @(posedge mclk);
        end while (host_ready !== 1'b1);
        q = host_data_out;
        // released pins must not keep showing the last value
        host_in <= {3'b111, ~a, ~d};
        do begin
            @(posedge mclk);
        end while (host_ready === 1'b1);
        repeat (gap) @(posedge mclk);
    endtask
endmodule

// file: tb/tb_top.sv
// self-checking bench for the host packing block
`include "hdp_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [47:0] RD = 48'h9abc_5678_def0;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [47:0] host_data_out, lw, pw, q;
    logic host_data_oe_n, host_ready, lwide, lup;
    logic int_ack = 1'b0;
    logic core_cfg_we = 1'b0;
    logic [31:0] core_cfg_wdata = 32'h0;
    logic [31:0] core_cfg_rdata;
    logic [1:0] pack_progress;
    hdp_pkg::hdp_host_s host_in;
    hdp_pkg::hdp_int_s int_out;
    // fifo channels agree with a 16-bit host and host-write direction
    hdp_pkg::hdp_chan_arr_t chan = {4{3'h2}};
    int error_cnt = 0;
    int n_compared = 0;
    int n_req = 0;
    always #5 mclk = ~mclk;
    hdp_host_model host_u (.mclk(mclk), .host_ready(host_ready),
        .host_data_out(host_data_out), .host_in(host_in));
    hdp_host_data_packing dut_u (.mclk(mclk), .reset(reset), .clk_en(1'b1), .host_in(host_in),
        .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n),
        .host_ready(host_ready), .int_out(int_out), .int_ack(int_ack), .int_rdata(RD),
        .channel_control(chan), .core_cfg_we(core_cfg_we), .core_cfg_wdata(core_cfg_wdata),
        .core_cfg_rdata(core_cfg_rdata), .pack_progress(pack_progress));
    // memory side answers one cycle after each request
    always @(posedge mclk) begin
        int_ack <= int_out.req && !int_ack;
        if (int_out.req && int_ack) begin
            n_req <= n_req + 1;
            pw <= lw;
            lw <= int_out.wdata;
            lwide <= int_out.wide48;
            lup <= int_out.upper32;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cfgw(input logic [31:0] v);
        @(posedge mclk);
        core_cfg_we <= 1'b1;
        core_cfg_wdata <= v;
        @(posedge mclk);
        core_cfg_we <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_host_cfg;
        host_u.acc(1'b1, 20'h0, 48'h0000_0050_0000, 0, q);
        host_u.acc(1'b1, 20'h0, 48'h0, 0, q);
        host_u.acc(1'b0, 20'h0, 48'h0, 0, q);
        chk("cfg read first", 48'h0, q);
        host_u.acc(1'b0, 20'h0, 48'h0, 0, q);
        chk("cfg read second", 48'h0000_0050_0000, q);
        host_u.acc(1'b1, 20'h0, 48'h0, 0, q);
        host_u.acc(1'b1, 20'h0, 48'h0000_0050_0000, 4, q);
        chk("cfg", 48'h50, {16'h0, core_cfg_rdata});
        $display("host config test done");
    endtask
    task automatic t_wr16;
        for (int o = 0; o < 2; o++) begin
            cfgw(o ? 32'h150 : 32'h10);
            host_u.acc(1'b1, 20'h10004, 48'h0000_1234_0000, 3, q);
            chk("progress", 48'h1, {46'h0, pack_progress});
            host_u.acc(1'b1, 20'h10004, 48'h0000_abcd_0000, 2, q);
            chk("wdata", o ? 48'h1234abcd : 48'habcd1234, {16'h0, lw[31:0]});
            chk("upper", 48'(o), {47'h0, lup});
        end
        $display("16-to-32 write test done");
    endtask
    task automatic t_rd16;
        int k;
        cfgw(32'h10);
        k = n_req;
        host_u.acc(1'b0, 20'h10008, 48'h0, 0, q);
        chk("rd first", 48'h0000_def0_0000, q);
        host_u.acc(1'b0, 20'h10008, 48'h0, 0, q);
        chk("rd second", 48'h0000_5678_0000, q);
        chk("fetches", 48'h1, 48'(n_req - k));
        $display("16-to-32 read test done");
    endtask
    task automatic t_pk48;
        int k;
        cfgw(32'h30);
        k = n_req;
        host_u.acc(1'b1, 20'h10010, 48'h1111_2222_0000, 0, q);
        host_u.acc(1'b1, 20'h10010, 48'h6666_3333_0000, 0, q);
        host_u.acc(1'b1, 20'h10010, 48'h4444_5555_0000, 2, q);
        chk("word1", 48'h1111_2222_3333, pw);
        chk("word2", 48'h4444_5555_6666, lw);
        chk("writes", 48'h2, 48'(n_req - k));
        cfgw(32'h20);
        host_u.acc(1'b1, 20'h10010, 48'h0000_3333_0000, 0, q);
        host_u.acc(1'b1, 20'h10010, 48'h0000_2222_0000, 0, q);
        host_u.acc(1'b1, 20'h10010, 48'h0000_1111_0000, 2, q);
        chk("word16", 48'h1111_2222_3333, lw);
        chk("wide", 48'h1, {47'h0, lwide});
        $display("48-bit packing test done");
    endtask
    task automatic t_flush;
        cfgw(32'h10);
        host_u.acc(1'b1, 20'h10004, 48'h0000_7777_0000, 0, q);
        chk("progress part", 48'h1, {46'h0, pack_progress});
        cfgw(32'h90);
        chk("progress flushed", 48'h0, {46'h0, pack_progress});
        chk("cfg after flush", 48'h10, {16'h0, core_cfg_rdata});
        $display("flush test done");
    endtask
    task automatic t_iwt;
        for (int v = 1; v >= 0; v--) begin
            cfgw(v ? 32'h8 : 32'h0);
            host_u.acc(1'b0, 20'h10000, 48'h0, 0, q);
            chk("iwt wide", 48'(v), {47'h0, lwide});
            if (v == 1) chk("rd48", 48'h9abc_5678_0000, q);
        end
        $display("instruction width test done");
    endtask
    task automatic t_iop;
        chan[1] <= 3'h4;
        cfgw(32'h10);
        for (int i = 1; i <= 3; i++) begin
            host_u.acc(1'b1, 20'h00041, {16'h0, 16'(i), 16'h0}, 0, q);
        end
        chk("fifo word", 48'h0003_0002_0001, lw);
        chk("fifo wide", 48'h1, {47'h0, lwide});
        cfgw(32'h20);
        for (int i = 0; i < 3; i++) begin
            host_u.acc(1'b1, 20'h00048, 48'h0, 0, q);
        end
        chk("link wide", 48'h1, {47'h0, lwide});
        host_u.acc(1'b1, 20'h00080, 48'h0000_00aa_0000, 0, q);
        host_u.acc(1'b1, 20'h00080, 48'h0000_00bb_0000, 2, q);
        chk("reg word", 48'h00bb_00aa, {16'h0, lw[31:0]});
        chk("reg wide", 48'h0, {47'h0, lwide});
        $display("fifo, link and register width test done");
    endtask
    task automatic t_reset;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        repeat (5) @(posedge mclk);
        chk("cfg reset", 48'h10, {16'h0, core_cfg_rdata});
        chk("progress reset", 48'h0, {46'h0, pack_progress});
        chk("ready reset", 48'h0, {47'h0, host_ready});
        $display("reset test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #50us;
        error_cnt++;
        summarize();
    end
    initial begin
        t_reset();
        t_host_cfg();
        t_wr16();
        t_rd16();
        t_pk48();
        t_flush();
        t_iwt();
        t_iop();
        summarize();
    end
endmodule
